// file: core/mfr_flash_core.sv
`timescale 1ns/1ps
`include "mfr_cfg.svh"
module mfr_flash_core #(
	parameter int PAGE_WRITE_CYCLES = `MFR_PAGE_WRITE_US * `MFR_CLK_MHZ
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	// serial link pins
	input  wire logic        cs_b_in,
	input  wire logic        sck_in,
	input  wire logic [3:0]  data_line_in,
	output logic      [3:0]  data_line_out,
	output logic      [3:0]  data_line_oe_out,
	// status and protection
	input  wire logic        quad_enable_bit_in,
	input  wire logic        page_locked_in,
	output logic      [15:0] lock_page_out,
	output logic             write_latch_flag_out,
	output logic             write_in_progress_out,
	output logic      [2:0]  wrap_bits_out,
	output logic             cont_mode_out,
	// array read port
	output logic      [23:0] mem_addr_out,
	input  wire logic [7:0]  mem_rdata_in,
	// array program port
	output logic             prog_we_out,
	output logic      [23:0] prog_addr_out,
	output logic      [7:0]  prog_data_out
);
	// ========================================
	// pin synchronisers and edge detection
	logic [5:0] pins_s;
	logic       cs_s, sck_s, cs_d, sck_d;
	logic [3:0] io_s;

	// cs idles high and sck low in mode 0, so no false edge after reset
	mfr_sync #(.W(6), .INIT(6'h20)) u_sync (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.d_in     ({cs_b_in, sck_in, data_line_in}),
		.q_out    (pins_s)
	);
	assign cs_s  = pins_s[5];
	assign sck_s = pins_s[4];
	assign io_s  = pins_s[3:0];

	// previous levels for edge finding
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cs_d  <= 1'b1;
			sck_d <= 1'b0;
		end else begin
			cs_d  <= cs_s;
			sck_d <= sck_s;
		end
	end

	logic cs_fall, cs_rise, rise, fall;
	assign cs_fall = cs_d & ~cs_s;
	assign cs_rise = ~cs_d & cs_s;
	assign rise    = ~cs_s & sck_s & ~sck_d;
	assign fall    = ~cs_s & ~sck_s & sck_d;

	// ========================================
	// command sequencer
	mfr_pkg::mfr_state_t state;
	logic [7:0]  cmd, cont_cmd, byte_q, mode_q;
	logic [23:0] addr_q;
	logic [31:0] sh, sh_next;
	logic [5:0]  cnt, cnt_next;
	logic [3:0]  dcnt, dneed;
	logic [2:0]  lw;
	logic        io_cmd, pgot, cont_active, write_in_progress, write_latch_flag;
	logic        addr_p, mode_p, byte_p, write_latch_set_cmd_p, wrap_p, go_p;

	assign io_cmd = (cmd == `MFR_OP_DIO) || (cmd == `MFR_OP_QIO) ||
			(cmd == `MFR_OP_QWORD);

	always_comb begin
		lw = 3'd1;
		if (state == mfr_pkg::ST_ADDR && cmd == `MFR_OP_DIO) begin
			lw = 3'd2;
		end else if (state == mfr_pkg::ST_ADDR && io_cmd) begin
			lw = 3'd4;
		end
	end

	// shift in one, two or four bits, highest line first
	always_comb begin
		case (lw)
			3'd4:    sh_next = {sh[27:0], io_s};
			3'd2:    sh_next = {sh[29:0], io_s[1:0]};
			default: sh_next = {sh[30:0], io_s[0]};
		endcase
		cnt_next = cnt + {3'd0, lw};
	end

	always_comb begin
		case (cmd)
			`MFR_OP_QIO:   dneed = `MFR_DUMMY_QIO;
			`MFR_OP_QWORD: dneed = `MFR_DUMMY_QWORD;
			default:       dneed = `MFR_DUMMY_QOUT;
		endcase
	end

	// opcode decode; only status reads pass while a write runs
	function automatic mfr_pkg::mfr_state_t f_decode(
		input logic [7:0] op,
		input logic       busy,
		input logic       qe,
		input logic       latch
	);
		mfr_pkg::mfr_state_t s;
		s = mfr_pkg::ST_IGNORE;
		case (op)
			`MFR_OP_QOUT, `MFR_OP_DIO: s = mfr_pkg::ST_ADDR;
			`MFR_OP_QIO, `MFR_OP_QWORD: begin
				s = qe ? mfr_pkg::ST_ADDR : mfr_pkg::ST_IGNORE;
			end
			`MFR_OP_WRAP: s = mfr_pkg::ST_WRAP;
			`MFR_OP_PROG: begin
				s = latch ? mfr_pkg::ST_ADDR : mfr_pkg::ST_IGNORE;
			end
			`MFR_OP_RDSR: s = mfr_pkg::ST_STATUS;
			default:      s = mfr_pkg::ST_IGNORE;
		endcase
		if (busy && op != `MFR_OP_RDSR) begin
			s = mfr_pkg::ST_IGNORE;
		end
		return s;
	endfunction

	// all input bits taken on rise
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state  <= mfr_pkg::ST_IDLE;
			cmd    <= 8'h00;
			sh     <= 32'h0000_0000;
			cnt    <= 6'h00;
			dcnt   <= 4'h0;
			pgot   <= 1'b0;
			addr_q <= 24'h00_0000;
			mode_q <= 8'h00;
			byte_q <= 8'h00;
			addr_p <= 1'b0;
			mode_p <= 1'b0;
			byte_p <= 1'b0;
			write_latch_set_cmd_p <= 1'b0;
			wrap_p <= 1'b0;
			go_p   <= 1'b0;
		end else begin
			addr_p <= 1'b0;
			mode_p <= 1'b0;
			byte_p <= 1'b0;
			write_latch_set_cmd_p <= 1'b0;
			wrap_p <= 1'b0;
			go_p   <= 1'b0;
			if (cs_fall) begin
				cnt  <= 6'h00;
				dcnt <= 4'h0;
				pgot <= 1'b0;
				if (cont_active && !write_in_progress) begin
					state <= mfr_pkg::ST_ADDR;
					cmd   <= cont_cmd;
				end else begin
					state <= mfr_pkg::ST_CMD;
				end
			end else if (cs_rise) begin
				if (state == mfr_pkg::ST_PDATA && cnt[2:0] == 3'd0 &&
						pgot && !page_locked_in) begin
					go_p <= 1'b1;
				end
				state <= mfr_pkg::ST_IDLE;
			end else if (rise) begin
				sh  <= sh_next;
				cnt <= cnt_next;
				case (state)
					mfr_pkg::ST_CMD: begin
						if (cnt_next == `MFR_CMD_BITS) begin
							cnt   <= 6'h00;
							cmd   <= sh_next[7:0];
							state <= f_decode(sh_next[7:0], write_in_progress,
									quad_enable_bit_in, write_latch_flag);
							write_latch_set_cmd_p <= (sh_next[7:0] == `MFR_OP_WRITE_LATCH_SET_CMD) && !write_in_progress;
						end
					end
					mfr_pkg::ST_ADDR: begin
						if (cnt_next == (io_cmd ? `MFR_AM_BITS :
								`MFR_ADDR_BITS)) begin
							cnt    <= 6'h00;
							addr_q <= io_cmd ? sh_next[31:8] : sh_next[23:0];
							mode_q <= sh_next[7:0];
							addr_p <= 1'b1;
							mode_p <= io_cmd;
							if (cmd == `MFR_OP_PROG) begin
								state <= mfr_pkg::ST_PDATA;
							end else if (cmd == `MFR_OP_DIO) begin
								state <= mfr_pkg::ST_DATA;
							end else begin
								state <= mfr_pkg::ST_DUMMY;
							end
						end
					end
					mfr_pkg::ST_DUMMY: begin
						dcnt <= dcnt + 4'd1;
						if (dcnt + 4'd1 == dneed) begin
							state <= mfr_pkg::ST_DATA;
						end
					end
					mfr_pkg::ST_WRAP: begin
						// wrap byte after 24 dummy bits
						if (cnt_next == `MFR_WRAP_BITS) begin
							byte_q <= sh_next[7:0];
							wrap_p <= 1'b1;
							state  <= mfr_pkg::ST_IGNORE;
						end
					end
					mfr_pkg::ST_PDATA: begin
						if (cnt_next[2:0] == 3'd0) begin
							byte_q <= sh_next[7:0];
							byte_p <= 1'b1;
							pgot   <= 1'b1;
						end
					end
					mfr_pkg::ST_DATA, mfr_pkg::ST_STATUS,
					mfr_pkg::ST_IGNORE, mfr_pkg::ST_IDLE: begin
					end
					default: state <= mfr_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// ========================================
	// continuous mode and wrap setting
	logic       wrap_dis;
	logic [1:0] wrap_len;
	logic [7:0] wmask;
	logic       wrap_on;

	// mode bits decide the next frame
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cont_active <= 1'b0;
			cont_cmd    <= 8'h00;
		end else if (mode_p) begin
			cont_active <= (mode_q[5:4] == `MFR_MODE_CONT);
			cont_cmd    <= cmd;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wrap_dis <= `MFR_WRAP_DIS_RST;
			wrap_len <= `MFR_WRAP_LEN_RST;
		end else if (wrap_p) begin
			wrap_dis <= byte_q[`MFR_WRAP_DIS];
			wrap_len <= byte_q[`MFR_WRAP_LEN_HI:`MFR_WRAP_LEN_LO];
		end
	end

	// wrap applies to quad io reads
	always_comb begin
		case (wrap_len)
			2'b00:   wmask = `MFR_MASK_8;
			2'b01:   wmask = `MFR_MASK_16;
			2'b10:   wmask = `MFR_MASK_32;
			default: wmask = `MFR_MASK_64;
		endcase
		wrap_on = !wrap_dis &&
			(cmd == `MFR_OP_QIO || cmd == `MFR_OP_QWORD);
	end

	// ========================================
	// output path: data driven on serial clock fall
	logic [23:0] rd_addr, rd_next;
	logic [7:0]  ob, ov, srcb;
	logic [3:0]  oleft;
	logic [2:0]  ow;
	logic [3:0]  omask;
	logic        load;

	always_comb begin
		ow    = 3'd4;
		omask = 4'hf;
		if (state == mfr_pkg::ST_STATUS) begin
			ow    = 3'd1;
			omask = 4'h2;
		end else if (cmd == `MFR_OP_DIO) begin
			ow    = 3'd2;
			omask = 4'h3;
		end
		load = (oleft == 4'd0);
		srcb = (state == mfr_pkg::ST_STATUS) ? {6'h00, write_latch_flag, write_in_progress} :
			mem_rdata_in;
		ov   = load ? srcb : ob;
	end

	always_comb begin
		rd_next = rd_addr + 24'd1;
		if (wrap_on) begin
			rd_next[7:0] = (rd_addr[7:0] & ~wmask) |
				((rd_addr[7:0] + 8'd1) & wmask);
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_addr          <= 24'h00_0000;
			ob               <= 8'h00;
			oleft            <= 4'd0;
			data_line_out    <= 4'h0;
			data_line_oe_out <= 4'h0;
		end else if (cs_s) begin
			oleft            <= 4'd0;
			data_line_oe_out <= 4'h0;
		end else if (addr_p) begin
			rd_addr <= addr_q;
			oleft   <= 4'd0;
		end else if (fall && (state == mfr_pkg::ST_DATA ||
				state == mfr_pkg::ST_STATUS)) begin
			data_line_oe_out <= omask;
			ob    <= 8'(ov << ow);
			oleft <= (load ? 4'd8 : oleft) - {1'b0, ow};
			case (ow)
				3'd4:    data_line_out <= ov[7:4];
				3'd2:    data_line_out <= {2'b00, ov[7:6]};
				default: data_line_out <= {2'b00, ov[7], 1'b0};
			endcase
			if (load && state == mfr_pkg::ST_DATA) begin
				rd_addr <= rd_next;
			end
		end
	end

	// ========================================
	// page write: buffer, sweep and timed cycle
	logic [15:0] pg;
	logic [7:0]  pidx, sw_idx, pb_data;
	logic        pb_valid, sw_act, tmr_act;
	logic [23:0] tmr;

	mfr_page_buf u_page (
		.clk_in       (clk_in),
		.rst_b_in     (rst_b_in),
		.clr_in       (addr_p && cmd == `MFR_OP_PROG),
		.wr_in        (byte_p),
		.wr_idx_in    (pidx),
		.wr_data_in   (byte_q),
		.rd_idx_in    (sw_idx),
		.rd_data_out  (pb_data),
		.rd_valid_out (pb_valid)
	);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pg   <= 16'h0000;
			pidx <= 8'h00;
		end else if (addr_p && cmd == `MFR_OP_PROG) begin
			pg   <= addr_q[23:8];
			pidx <= addr_q[7:0];
		end else if (byte_p) begin
			pidx <= pidx + 8'd1;
		end
	end

	// sweep valid bytes then hold busy
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sw_act        <= 1'b0;
			sw_idx        <= 8'h00;
			tmr_act       <= 1'b0;
			tmr           <= 24'h00_0000;
			write_latch_flag           <= 1'b0;
			prog_we_out   <= 1'b0;
			prog_addr_out <= 24'h00_0000;
			prog_data_out <= 8'h00;
		end else begin
			prog_we_out <= sw_act && pb_valid;
			if (sw_act) begin
				prog_addr_out <= {pg, sw_idx};
				prog_data_out <= pb_data;
				sw_idx        <= sw_idx + 8'd1;
				if (sw_idx == `MFR_PAGE_LAST) begin
					sw_act  <= 1'b0;
					tmr_act <= 1'b1;
					tmr     <= 24'h00_0000;
					write_latch_flag     <= 1'b0;
				end
			end else if (tmr_act) begin
				tmr <= tmr + 24'd1;
				if (tmr == 24'(PAGE_WRITE_CYCLES - 1)) begin
					tmr_act <= 1'b0;
				end
			end else if (go_p) begin
				sw_act <= 1'b1;
				sw_idx <= 8'h00;
			end
			if (write_latch_set_cmd_p) begin
				write_latch_flag <= 1'b1;
			end
		end
	end

	assign write_in_progress                   = sw_act | tmr_act | go_p;
	assign write_in_progress_out = write_in_progress;
	assign write_latch_flag_out  = write_latch_flag;
	assign lock_page_out         = pg;
	assign mem_addr_out          = rd_addr;
	assign wrap_bits_out         = {wrap_len, wrap_dis};
	assign cont_mode_out         = cont_active;

	// ========================================
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_prog_end;
		cs_rise && state == mfr_pkg::ST_PDATA;
	endsequence

	quad_out_lines_a: assert property (
		(state == mfr_pkg::ST_DATA && cmd == `MFR_OP_QOUT && fall)
		|=> data_line_oe_out == 4'hf)
		else $error("quad output not on four lines");
	rise_only_a: assert property (
		(!cs_fall && !cs_rise && $changed(cnt) && cnt != 6'h00)
		|-> $past(rise))
		else $error("input bit taken without clock rise");
	addr_step_a: assert property (
		(fall && load && state == mfr_pkg::ST_DATA && !wrap_on && !cs_s)
		|=> rd_addr == $past(rd_addr) + 24'd1)
		else $error("read address did not step by one");
	dual_lines_a: assert property (
		(state == mfr_pkg::ST_DATA && cmd == `MFR_OP_DIO && fall)
		|=> data_line_oe_out == 4'h3)
		else $error("dual read not on two lines");
	cont_entry_a: assert property (
		(cs_fall && cont_active && !write_in_progress)
		|=> state == mfr_pkg::ST_ADDR && cmd == $past(cont_cmd))
		else $error("continuous frame did not skip opcode");
	cont_exit_a: assert property (
		(mode_p && mode_q[5:4] != `MFR_MODE_CONT) |=> !cont_active)
		else $error("continuous mode not left");
	quad_dummy_a: assert property (
		(state == mfr_pkg::ST_DUMMY && cmd == `MFR_OP_QIO &&
			$past(state) == mfr_pkg::ST_ADDR) |-> dcnt == 4'd0 ##0
		(state == mfr_pkg::ST_DUMMY)[*1])
		else $error("quad dummy count wrong");
	quad_gate_a: assert property (
		(rise && state == mfr_pkg::ST_CMD && cnt_next == `MFR_CMD_BITS &&
			sh_next[7:0] == `MFR_OP_QIO && !quad_enable_bit_in)
		|=> state == mfr_pkg::ST_IGNORE)
		else $error("quad read honoured without enable");
	word_dummy_a: assert property (
		($rose(state == mfr_pkg::ST_DATA) && cmd == `MFR_OP_QWORD)
		|-> $past(dcnt) == 4'd1)
		else $error("word read dummy count not two");
	wrap_section_a: assert property (
		(fall && load && state == mfr_pkg::ST_DATA && wrap_on && !cs_s)
		|=> rd_addr[23:6] == $past(rd_addr[23:6]))
		else $error("wrap left its section");
	wrap_enable_a: assert property (
		wrap_p |=> wrap_dis == $past(byte_q[`MFR_WRAP_DIS]))
		else $error("wrap enable bit not stored");
	byte_boundary_a: assert property (
		(s_prog_end and (cnt[2:0] != 3'd0)) |=> !go_p)
		else $error("partial byte page write started");
	busy_start_a: assert property (
		go_p |=> write_in_progress_out [*8])
		else $error("busy flag not held after page write");
	locked_page_a: assert property (
		(s_prog_end and page_locked_in) |=> !go_p)
		else $error("page write to locked page started");
	latch_need_a: assert property (
		(state == mfr_pkg::ST_PDATA) |-> write_latch_flag || write_in_progress)
		else $error("page write accepted without latch");
endmodule

// file: core/mfr_cfg.svh
`ifndef MFR_CFG_SVH
`define MFR_CFG_SVH
`define MFR_OP_QOUT     8'h6b
`define MFR_OP_DIO      8'hbb
`define MFR_OP_QIO      8'heb
`define MFR_OP_QWORD    8'he7
`define MFR_OP_WRAP     8'h77
`define MFR_OP_PROG     8'h02
`define MFR_OP_WRITE_LATCH_SET_CMD     8'h06
`define MFR_OP_RDSR     8'h05
`define MFR_CMD_BITS    6'd8
`define MFR_ADDR_BITS   6'd24
`define MFR_AM_BITS     6'd32
`define MFR_WRAP_BITS   6'd32
`define MFR_DUMMY_QOUT  4'd8
`define MFR_DUMMY_QIO   4'd4
`define MFR_DUMMY_QWORD 4'd2
`define MFR_MODE_CONT   2'b10
`define MFR_WRAP_DIS    4
`define MFR_WRAP_LEN_HI 6
`define MFR_WRAP_LEN_LO 5
`define MFR_WRAP_DIS_RST 1'b1
`define MFR_WRAP_LEN_RST 2'b00
`define MFR_MASK_8      8'h07
`define MFR_MASK_16     8'h0f
`define MFR_MASK_32     8'h1f
`define MFR_MASK_64     8'h3f
`define MFR_PAGE_LAST   8'hff
`define MFR_CLK_MHZ     20
`define MFR_PAGE_WRITE_US 600
`endif

// file: core/mfr_pkg.sv
package mfr_pkg;
	// command sequencer phases
	typedef enum logic [3:0] {
		ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA,
		ST_WRAP, ST_PDATA, ST_STATUS, ST_IGNORE
	} mfr_state_t;
endpackage

// file: core/mfr_sync.sv
`timescale 1ns/1ps
// two flop synchroniser, first stage read only by the second
module mfr_sync #(
	parameter int         W    = 1,
	parameter logic [5:0] INIT = 6'h00
) (
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta;

	// resets to the idle level of the pins
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta  <= INIT[W-1:0];
			q_out <= INIT[W-1:0];
		end else begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule

// file: core/mfr_page_buf.sv
`timescale 1ns/1ps
// one page of write data plus a per-byte valid mask
module mfr_page_buf (
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	// fill side
	input  wire logic       clr_in,
	input  wire logic       wr_in,
	input  wire logic [7:0] wr_idx_in,
	input  wire logic [7:0] wr_data_in,
	// drain side
	input  wire logic [7:0] rd_idx_in,
	output logic      [7:0] rd_data_out,
	output logic            rd_valid_out
);
	logic [7:0]   mem [256];
	logic [255:0] valid;

	// later bytes to the same slot overwrite, so only the last 256 survive
	always_ff @(posedge clk_in) begin
		if (wr_in) begin
			mem[wr_idx_in] <= wr_data_in;
		end
	end

	// untouched slots stay invalid and leave the page unchanged
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			valid <= '0;
		end else if (clr_in) begin
			valid <= '0;
		end else if (wr_in) begin
			valid[wr_idx_in] <= 1'b1;
		end
	end

	assign rd_data_out  = mem[rd_idx_in];
	assign rd_valid_out = valid[rd_idx_in];
endmodule

// file: tb/mfr_host_model.sv
`timescale 1ns/1ps
// host controller model: sck mode 0, 400 ns period, stands still between frames
module mfr_host_model (
	// link pins
	output logic            cs_b_out,
	output logic            sck_out,
	output logic      [3:0] dout_out,
	output logic      [3:0] oe_out,
	input  wire logic [3:0] din_in
);
	logic [3:0] rx;
	// idle: deselected, clock low, lines released
	initial begin
		cs_b_out = 1'b1;
		sck_out = 1'b0;
		dout_out = 4'h0;
		oe_out = 4'h0;
	end
	// change on fall, device takes on rise
	task automatic cyc(input logic [3:0] d, input logic [3:0] oe);
		sck_out = 1'b0;
		dout_out = d;
		oe_out = oe;
		#200;
		sck_out = 1'b1;
		#190;
		rx = din_in; // read data holds until the next fall
		#10;
	endtask
	// right-justified value, msb first, w lines wide
	task automatic send(input logic [31:0] v, input int n, input int w);
		logic [3:0] m;
		m = 4'((1 << w) - 1);
		v = v << (32 - n);
		for (int i = 0; i < n; i += w) begin
			cyc(4'(v >> (32 - w)) & m, m);
			v = v << w;
		end
	endtask
	// one byte in; single-line answers come on line 1
	task automatic get(input int w, output logic [7:0] b);
		b = 8'h00;
		for (int i = 0; i < 8; i += w) begin
			cyc(4'h0, 4'h0);
			b = (b << w) | ((w == 1) ? 8'(rx[1]) : 8'(rx & 4'((1 << w) - 1)));
		end
	endtask
	task automatic open_f();
		cs_b_out = 1'b0;
	endtask
	// deselect after a low phase, then two idle sck periods
	task automatic close_f();
		sck_out = 1'b0;
		oe_out = 4'h0;
		#200;
		cs_b_out = 1'b1;
		#800;
	endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	// one ordinary read: opcode, address, widths and dummy clocks
	typedef struct {
		logic [7:0]  op;
		logic [23:0] a;
		int          aw;
		int          dmy;
		int          dw;
	} mfr_row_t;
	logic        clk, rst_b, qe, locked, oe_seen;
	logic [3:0]  dl, d_out, d_oe, idle, h_d, h_oe;
	logic        h_cs, h_sck, busy, latch, cont, we;
	logic [2:0]  wrap;
	logic [15:0] page;
	logic [23:0] ma, pa, a;
	logic [7:0]  pd;
	logic [7:0]  got [3];
	logic [31:0] pq [$];
	int          failures, check_count;
	mfr_row_t    rows [4] = '{
		'{8'h6b, 24'h0012a7, 1, 8, 4},
		'{8'hbb, 24'h00340f, 2, 0, 2},
		'{8'heb, 24'h0056ff, 4, 4, 4},
		'{8'he7, 24'h007812, 4, 2, 4}
	};
	// array contents and page data patterns
	function automatic logic [7:0] mb(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ 8'h5a;
	endfunction
	function automatic logic [7:0] pv(input int k);
		return 8'(k >> 1) ^ 8'ha5;
	endfunction
	mfr_flash_core #(.PAGE_WRITE_CYCLES(20)) u_dut (
		.clk_in(clk), .rst_b_in(rst_b), .cs_b_in(h_cs), .sck_in(h_sck),
		.data_line_in(dl), .data_line_out(d_out), .data_line_oe_out(d_oe),
		.quad_enable_bit_in(qe), .page_locked_in(locked),
		.lock_page_out(page), .write_latch_flag_out(latch),
		.write_in_progress_out(busy), .wrap_bits_out(wrap),
		.cont_mode_out(cont), .mem_addr_out(ma), .mem_rdata_in(mb(ma)),
		.prog_we_out(we), .prog_addr_out(pa), .prog_data_out(pd));
	mfr_host_model u_host (.cs_b_out(h_cs), .sck_out(h_sck),
		.dout_out(h_d), .oe_out(h_oe), .din_in(dl));
	initial clk = 1'b0;
	always #25 clk = ~clk;
	// wire level; an undriven line toggles so stale values never match
	always_comb
		for (int i = 0; i < 4; i++)
			dl[i] = d_oe[i] ? d_out[i] : (h_oe[i] ? h_d[i] : idle[i]);
	// program pulses and any drive are recorded
	always @(posedge clk) begin
		idle <= ~idle;
		if (we === 1'b1) pq.push_back({pa, pd});
		if (d_oe !== 4'h0) oe_seen <= 1'b1;
	end
	task automatic chk_d(input string n, input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_s(input string n, input logic [23:0] e, g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic do_rst();
		@(posedge clk);
		#2;
		rst_b = 1'b0;
		repeat (4) @(posedge clk);
		#2;
		rst_b = 1'b1;
		repeat (4) @(posedge clk);
		#2;
	endtask
	task automatic rd(input logic [7:0] op, input logic [23:0] x,
		input logic [7:0] m, input int aw, dmy, dw, skip, n);
		u_host.open_f();
		if (!skip) u_host.send(32'(op), 8, 1);
		if (aw == 1) u_host.send(32'(x), 24, 1);
		else u_host.send({x, m}, 32, aw);
		repeat (dmy) u_host.cyc(4'h0, 4'h0);
		for (int k = 0; k < n; k++) u_host.get(dw, got[k]);
		u_host.close_f();
	endtask
	task automatic ctl(input logic [7:0] op, input int n, input logic [31:0] v);
		u_host.open_f();
		u_host.send(32'(op), 8, 1);
		if (n > 0) u_host.send(v, n, 1);
		u_host.close_f();
	endtask
	task automatic pp(input logic [23:0] x, input int n, extra);
		u_host.open_f();
		u_host.send({8'h02, x}, 32, 1);
		for (int k = 0; k < n; k++) u_host.send(32'(pv(k)), 8, 1);
		if (extra > 0) u_host.send(32'h0, extra, 1);
		u_host.close_f();
	endtask
	// expected pulses in page order, later bytes overwrite earlier ones
	task automatic pchk(input logic [23:0] x, input int n);
		logic [7:0] e [256];
		logic       v [256];
		for (int i = 0; i < 256; i++) v[i] = 1'b0;
		for (int k = 0; k < n; k++) begin
			e[8'(x[7:0] + k)] = pv(k);
			v[8'(x[7:0] + k)] = 1'b1;
		end
		for (int i = 0; i < 256; i++)
			if (v[i]) begin
				chk_s("prog addr", {x[23:8], 8'(i)}, pq[0][31:8]);
				chk_d("prog data", e[i], pq[0][7:0]);
				void'(pq.pop_front());
			end
		chk_s("extra prog", 24'h0, 24'(pq.size()));
	endtask
	task automatic wait_idle();
		for (int t = 0; t < 4000 && busy !== 1'b0; t++) @(posedge clk);
		#2;
		chk_s("busy end", 24'h0, 24'(busy));
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// watchdog well past the roughly 1.2 ms the sequence needs
	initial begin
		#3000000;
		failures++;
		wrap_up();
	end
	initial begin
		rst_b = 1'b0;
		qe = 1'b1;
		locked = 1'b0;
		oe_seen = 1'b0;
		idle = 4'h5;
		failures = 0;
		check_count = 0;
		do_rst();
		chk_s("wrap rst", 24'h1, 24'(wrap));
		// table of ordinary reads, two bytes each
		foreach (rows[i]) begin
			rd(rows[i].op, rows[i].a, 8'h00, rows[i].aw, rows[i].dmy,
				rows[i].dw, 0, 2);
			for (int k = 0; k < 2; k++)
				chk_d("rd", mb(rows[i].a + 24'(k)), got[k]);
		end
		rd(8'heb, 24'h00a0f3, 8'h20, 4, 4, 4, 0, 1);
		chk_s("cont on", 24'h1, 24'(cont));
		rd(8'h00, 24'h00b001, 8'h00, 4, 4, 4, 1, 1);
		chk_d("cont rd", mb(24'h00b001), got[0]);
		chk_s("cont off", 24'h0, 24'(cont));
		qe = 1'b0;
		oe_seen = 1'b0;
		rd(8'heb, 24'h000010, 8'h00, 4, 4, 4, 0, 1);
		chk_s("qe drive", 24'h0, 24'(oe_seen));
		qe = 1'b1;
		// every wrap length, read across the section end
		for (int l = 0; l < 4; l++) begin
			ctl(8'h77, 32, 32'(l << 5));
			chk_s("wrap bits", 24'(l << 1), 24'(wrap));
			a = 24'h001000 + 24'((8 << l) - 2);
			rd(l[0] ? 8'he7 : 8'heb, a, 8'h00, 4, l[0] ? 2 : 4, 4, 0, 3);
			chk_d("wrap b1", mb(a + 24'h1), got[1]);
			chk_d("wrap b2", mb(24'h001000), got[2]);
		end
		ctl(8'h77, 32, 32'h10);
		chk_s("wrap off", 24'h1, 24'(wrap));
		rd(8'heb, 24'h001007, 8'h00, 4, 4, 4, 0, 2);
		chk_d("linear", mb(24'h001008), got[1]);
		ctl(8'h06, 0, 0);
		chk_s("latch set", 24'h1, 24'(latch));
		pp(24'h0012fe, 3, 0);
		chk_s("busy", 24'h1, 24'(busy));
		chk_s("page", 24'h12, 24'(page));
		u_host.open_f();
		u_host.send(32'h05, 8, 1);
		u_host.get(1, got[0]);
		u_host.close_f();
		chk_d("status", 8'h03, got[0]);
		wait_idle();
		chk_s("latch clr", 24'h0, 24'(latch));
		pchk(24'h0012fe, 3);
		ctl(8'h06, 0, 0);
		pp(24'h003400, 258, 0);
		wait_idle();
		pchk(24'h003400, 258);
		// refused: no latch, ragged end, locked page
		for (int c = 0; c < 3; c++) begin
			if (c > 0) ctl(8'h06, 0, 0);
			locked = (c == 2);
			pp(24'h005600, 2, c == 1 ? 4 : 0);
			chk_s("refused", 24'h0, 24'(busy));
			chk_s("no prog", 24'h0, 24'(pq.size()));
			locked = 1'b0;
		end
		// reset in mid-run drops wrap and continuous mode
		ctl(8'h77, 32, 32'h0);
		rd(8'heb, 24'h000000, 8'h20, 4, 4, 4, 0, 1);
		do_rst();
		chk_s("wrap rst2", 24'h1, 24'(wrap));
		chk_s("cont rst", 24'h0, 24'(cont));
		chk_s("latch rst", 24'h0, 24'(latch));
		wrap_up();
	end
endmodule
